// File: fcd_consts.svh
// fcd_consts.svh: named numbers for the fixture command decoder
// assumes: included by bare name from the decoder module and from the bench
`ifndef FCD_CONSTS_SVH
`define FCD_CONSTS_SVH

`define FCD_SLOTS         12
`define FCD_AXES          5
`define FCD_LIMITS        6
// default slot positions, zero based
`define FCD_SLOT_PAN      4'h0
`define FCD_SLOT_TILT     4'h2
`define FCD_SLOT_COLOR    4'h4
`define FCD_SLOT_SHUTTER  4'h6
`define FCD_SLOT_FOCUS    4'h8
`define FCD_SLOT_CMD      4'hA
`define FCD_SLOT_ACT      4'hB
`define FCD_SLOT_LAST     4'hB
// command code lower bounds, each band runs up to the next bound minus one
`define FCD_C_PAN_MIN     8'h33
`define FCD_C_PAN_MAX     8'h3F
`define FCD_C_TILT_MIN    8'h4D
`define FCD_C_TILT_MAX    8'h59
`define FCD_C_FOC_MIN     8'h66
`define FCD_C_FOC_MAX     8'h73
`define FCD_C_RECAL_PT    8'h80
`define FCD_C_RECAL_FOC   8'h8C
`define FCD_C_RECAL_COL   8'h99
`define FCD_C_RECAL_SHU   8'hA6
`define FCD_C_RECAL_ALL   8'hB3
`define FCD_C_SERVO_OFF   8'hBF
`define FCD_C_SERVO_ON    8'hCC
`define FCD_C_LAMP_OFF    8'hD9
`define FCD_C_LAMP_ON     8'hE6
`define FCD_C_NONE_HI     8'hF2
// activate slot levels
`define FCD_ACT_IDLE_HI   8'h09
`define FCD_ACT_RESET     8'h82
`define FCD_ACT_ON_LO     8'hE6
// hold time before a command runs
`define FCD_HOLD_TIME_MS  1000
`define FCD_CLK_KHZ       200000
`define FCD_HOLD_CYCLES   (`FCD_HOLD_TIME_MS * `FCD_CLK_KHZ)
// reset values
`define FCD_LIM_MIN_RST   16'h0000
`define FCD_LIM_MAX_RST   16'hFFFF
`define FCD_POS_RST       16'h0000
`define FCD_SPD_RST       8'h00

`endif

// File: fcd_pkg.sv
// fcd_pkg.sv: types for the fixture command decoder
// assumes: nothing beyond the constants header
package fcd_pkg;
    typedef enum logic [1:0] {
        FCD_ST_IDLE = 2'b00,
        FCD_ST_HOLD = 2'b01,
        FCD_ST_DONE = 2'b10
    } fcd_state_t;

    typedef enum logic [3:0] {
        FCD_CMD_NONE      = 4'b0000,
        FCD_CMD_PAN_MIN   = 4'b0001,
        FCD_CMD_PAN_MAX   = 4'b0010,
        FCD_CMD_TILT_MIN  = 4'b0011,
        FCD_CMD_TILT_MAX  = 4'b0100,
        FCD_CMD_FOC_MIN   = 4'b0101,
        FCD_CMD_FOC_MAX   = 4'b0110,
        FCD_CMD_RECAL_PT  = 4'b0111,
        FCD_CMD_RECAL_FOC = 4'b1000,
        FCD_CMD_RECAL_COL = 4'b1001,
        FCD_CMD_RECAL_SHU = 4'b1010,
        FCD_CMD_RECAL_ALL = 4'b1011,
        FCD_CMD_SERVO_OFF = 4'b1100,
        FCD_CMD_SERVO_ON  = 4'b1101,
        FCD_CMD_LAMP_OFF  = 4'b1110,
        FCD_CMD_LAMP_ON   = 4'b1111
    } fcd_cmd_t;

    typedef enum logic [1:0] {
        FCD_ACT_IDLE  = 2'b00,
        FCD_ACT_RESET = 2'b01,
        FCD_ACT_ON    = 2'b10,
        FCD_ACT_OTHER = 2'b11
    } fcd_act_t;
endpackage : fcd_pkg

// File: fcd_decoder.sv
// fcd_decoder.sv: slot value decoder and remote command interpreter of a searchlight fixture
// assumes: slot bytes arrive already addressed, one per slot_wr pulse, frame_done after the last
//
// Summary of operation
// - pan target from slots 1 and 2
// - tilt target from slots 3 and 4
// - color roll slots 5,6; zero first frame
// - shutter slots 7,8; zero closed, full open
// - focus slots 9,10; zero spot, full flood
// - slot 11 command; 0-50, 242-255 no action
// - codes 51-62 pan min, 63-76 pan max
// - codes 77-88 tilt min, 89-101 tilt max
// - codes 102-114 focus min, 115-127 focus max
// - 128-139 recal pan/tilt, 140-152 recal focus
// - 153-165 color, 166-178 shutter, 179-190 all recal
// - 191-203 servos off, 204-216 servos on
// - 217-229 lamp off, 230-241 lamp strike
// - slot 12: 0-9 idle, 130 reset, 230-255 activate
// - follow mode takes new slot values at each frame_done
// - speed mode reads one speed slot per axis
// - per axis width in follow mode and per function slot offset configurable
// - first slot high byte, second low byte
// - speed layout: position odd, speed even slot
// - set captures position; reset restores full range
`timescale 1ns/1ps
`include "fcd_consts.svh"

module fcd_decoder #(
    parameter int unsigned HOLD_CYCLES = `FCD_HOLD_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic                  slot_wr,
    input  wire logic [3:0]            slot_idx,
    input  wire logic [7:0]            slot_data,
    input  wire logic                  frame_done,
    input  wire logic                  speed_mode,
    input  wire logic [4:0]            axis_wide,
    input  wire logic [6:0][3:0]       fn_slot,
    output logic      [4:0][15:0]      axis_pos,
    output logic      [4:0][7:0]       axis_speed,
    output logic      [5:0][15:0]      limit_word,
    output logic      [3:0]            recal_pulse,
    output logic                       servo_enable,
    output logic                       lamp_enable,
    output logic                       lamp_strike,
    output logic                       cmd_done
);

    // ==========================================================
    // helpers
    function automatic logic [15:0] slot_word(input logic [11:0][7:0] s,
                                              input logic [3:0] b, input logic wide);
        logic [3:0] b1;
        b1 = 4'(b + 4'h1);
        if (b > `FCD_SLOT_LAST) begin
            slot_word = `FCD_POS_RST;
        end else if (wide && b < `FCD_SLOT_LAST) begin
            slot_word = {s[b], s[b1]};
        end else begin
            slot_word = {s[b], s[b]};
        end
    endfunction : slot_word

    function automatic logic [7:0] slot_byte(input logic [11:0][7:0] s, input logic [3:0] b);
        if (b > `FCD_SLOT_LAST) begin
            slot_byte = `FCD_SPD_RST;
        end else begin
            slot_byte = s[b];
        end
    endfunction : slot_byte

    function automatic fcd_pkg::fcd_cmd_t decode_cmd(input logic [7:0] c);
        if (c < `FCD_C_PAN_MIN || c >= `FCD_C_NONE_HI) decode_cmd = fcd_pkg::FCD_CMD_NONE;
        else if (c < `FCD_C_PAN_MAX) decode_cmd = fcd_pkg::FCD_CMD_PAN_MIN;
        else if (c < `FCD_C_TILT_MIN) decode_cmd = fcd_pkg::FCD_CMD_PAN_MAX;
        else if (c < `FCD_C_TILT_MAX) decode_cmd = fcd_pkg::FCD_CMD_TILT_MIN;
        else if (c < `FCD_C_FOC_MIN) decode_cmd = fcd_pkg::FCD_CMD_TILT_MAX;
        else if (c < `FCD_C_FOC_MAX) decode_cmd = fcd_pkg::FCD_CMD_FOC_MIN;
        else if (c < `FCD_C_RECAL_PT) decode_cmd = fcd_pkg::FCD_CMD_FOC_MAX;
        else if (c < `FCD_C_RECAL_FOC) decode_cmd = fcd_pkg::FCD_CMD_RECAL_PT;
        else if (c < `FCD_C_RECAL_COL) decode_cmd = fcd_pkg::FCD_CMD_RECAL_FOC;
        else if (c < `FCD_C_RECAL_SHU) decode_cmd = fcd_pkg::FCD_CMD_RECAL_COL;
        else if (c < `FCD_C_RECAL_ALL) decode_cmd = fcd_pkg::FCD_CMD_RECAL_SHU;
        else if (c < `FCD_C_SERVO_OFF) decode_cmd = fcd_pkg::FCD_CMD_RECAL_ALL;
        else if (c < `FCD_C_SERVO_ON) decode_cmd = fcd_pkg::FCD_CMD_SERVO_OFF;
        else if (c < `FCD_C_LAMP_OFF) decode_cmd = fcd_pkg::FCD_CMD_SERVO_ON;
        else if (c < `FCD_C_LAMP_ON) decode_cmd = fcd_pkg::FCD_CMD_LAMP_OFF;
        else decode_cmd = fcd_pkg::FCD_CMD_LAMP_ON;
    endfunction : decode_cmd

    // ==========================================================
    // slot store and axis targets
    logic [11:0][7:0] slot_reg, slot_next;
    logic [4:0][15:0] pos_reg, pos_next;
    logic [4:0][7:0]  spd_reg, spd_next;

    always_comb begin
        slot_next = slot_reg;
        pos_next  = pos_reg;
        spd_next  = spd_reg;
        if (slot_wr && slot_idx <= `FCD_SLOT_LAST) begin
            slot_next[slot_idx] = slot_data;
        end
        if (frame_done) begin
            for (int i = 0; i < `FCD_AXES; i++) begin
                if (speed_mode) begin
                    pos_next[i] = slot_word(slot_reg, fn_slot[i], 1'b0);
                    spd_next[i] = slot_byte(slot_reg, 4'(fn_slot[i] + 4'h1));
                end else begin
                    pos_next[i] = slot_word(slot_reg, fn_slot[i], axis_wide[i]);
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slot_reg <= '0;
            pos_reg  <= '0;
            spd_reg  <= '0;
        end else begin
            slot_reg <= slot_next;
            pos_reg  <= pos_next;
            spd_reg  <= spd_next;
        end
    end

    // ==========================================================
    // activation hold and command execution
    logic [7:0]         act_byte;
    fcd_pkg::fcd_act_t  act_cls;
    fcd_pkg::fcd_cmd_t  cmd_live;
    fcd_pkg::fcd_state_t st_reg, st_next;
    fcd_pkg::fcd_act_t  held_reg, held_next;
    logic [27:0]        cnt_reg, cnt_next;
    logic               exec;

    always_comb begin
        act_byte = slot_byte(slot_reg, fn_slot[6]);
        cmd_live = decode_cmd(slot_byte(slot_reg, fn_slot[5]));
        if (act_byte <= `FCD_ACT_IDLE_HI) begin
            act_cls = fcd_pkg::FCD_ACT_IDLE;
        end else if (act_byte == `FCD_ACT_RESET) begin
            act_cls = fcd_pkg::FCD_ACT_RESET;
        end else if (act_byte >= `FCD_ACT_ON_LO) begin
            act_cls = fcd_pkg::FCD_ACT_ON;
        end else begin
            act_cls = fcd_pkg::FCD_ACT_OTHER;
        end
    end

    always_comb begin
        st_next   = st_reg;
        held_next = held_reg;
        cnt_next  = cnt_reg;
        exec      = 1'b0;
        case (st_reg)
            fcd_pkg::FCD_ST_IDLE: begin
                cnt_next = '0;
                if ((act_cls == fcd_pkg::FCD_ACT_ON || act_cls == fcd_pkg::FCD_ACT_RESET)
                    && cmd_live != fcd_pkg::FCD_CMD_NONE) begin
                    st_next   = fcd_pkg::FCD_ST_HOLD;
                    held_next = act_cls;
                end
            end
            fcd_pkg::FCD_ST_HOLD: begin
                if (act_cls != held_reg || cmd_live == fcd_pkg::FCD_CMD_NONE) begin
                    st_next = fcd_pkg::FCD_ST_IDLE;
                end else if (cnt_reg >= 28'(HOLD_CYCLES - 1)) begin
                    exec    = 1'b1;
                    st_next = fcd_pkg::FCD_ST_DONE;
                end else begin
                    cnt_next = 28'(cnt_reg + 28'h1);
                end
            end
            fcd_pkg::FCD_ST_DONE: begin
                cnt_next = '0;
                if (act_cls == fcd_pkg::FCD_ACT_IDLE) begin
                    st_next = fcd_pkg::FCD_ST_IDLE;
                end
            end
            default: begin
                st_next = fcd_pkg::FCD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg   <= fcd_pkg::FCD_ST_IDLE;
            held_reg <= fcd_pkg::FCD_ACT_IDLE;
            cnt_reg  <= '0;
        end else begin
            st_reg   <= st_next;
            held_reg <= held_next;
            cnt_reg  <= cnt_next;
        end
    end

    // ==========================================================
    // command effects
    logic [5:0][15:0] lim_reg, lim_next;
    logic [3:0]       recal_reg, recal_next;
    logic             servo_reg, servo_next;
    logic             lamp_reg, lamp_next;
    logic             strike_reg, strike_next;
    logic             done_reg, done_next;
    logic [2:0]       lim_i;

    always_comb begin
        lim_next    = lim_reg;
        recal_next  = '0;
        servo_next  = servo_reg;
        lamp_next   = lamp_reg;
        strike_next = 1'b0;
        done_next   = exec;
        lim_i       = 3'(cmd_live - 4'h1);
        if (exec) begin
            case (cmd_live)
                fcd_pkg::FCD_CMD_PAN_MIN, fcd_pkg::FCD_CMD_PAN_MAX,
                fcd_pkg::FCD_CMD_TILT_MIN, fcd_pkg::FCD_CMD_TILT_MAX,
                fcd_pkg::FCD_CMD_FOC_MIN, fcd_pkg::FCD_CMD_FOC_MAX: begin
                    if (held_reg == fcd_pkg::FCD_ACT_RESET) begin
                        lim_next[lim_i] = lim_i[0] ? `FCD_LIM_MAX_RST : `FCD_LIM_MIN_RST;
                    end else begin
                        lim_next[lim_i] = pos_reg[lim_i >= 3'h4 ? 3'h4 : 3'(lim_i >> 1)];
                    end
                end
                fcd_pkg::FCD_CMD_RECAL_PT:  recal_next = 4'h1;
                fcd_pkg::FCD_CMD_RECAL_FOC: recal_next = 4'h2;
                fcd_pkg::FCD_CMD_RECAL_COL: recal_next = 4'h4;
                fcd_pkg::FCD_CMD_RECAL_SHU: recal_next = 4'h8;
                fcd_pkg::FCD_CMD_RECAL_ALL: recal_next = 4'hF;
                fcd_pkg::FCD_CMD_SERVO_OFF: servo_next = 1'b0;
                fcd_pkg::FCD_CMD_SERVO_ON:  servo_next = 1'b1;
                fcd_pkg::FCD_CMD_LAMP_OFF:  lamp_next  = 1'b0;
                fcd_pkg::FCD_CMD_LAMP_ON: begin
                    lamp_next   = 1'b1;
                    strike_next = 1'b1;
                end
                default: begin
                    done_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < `FCD_LIMITS; i++) begin
                lim_reg[i] <= (i % 2 == 1) ? `FCD_LIM_MAX_RST : `FCD_LIM_MIN_RST;
            end
            recal_reg  <= '0;
            servo_reg  <= 1'b1;
            lamp_reg   <= 1'b0;
            strike_reg <= 1'b0;
            done_reg   <= 1'b0;
        end else begin
            lim_reg    <= lim_next;
            recal_reg  <= recal_next;
            servo_reg  <= servo_next;
            lamp_reg   <= lamp_next;
            strike_reg <= strike_next;
            done_reg   <= done_next;
        end
    end

    assign axis_pos     = pos_reg;
    assign axis_speed   = spd_reg;
    assign limit_word   = lim_reg;
    assign recal_pulse  = recal_reg;
    assign servo_enable = servo_reg;
    assign lamp_enable  = lamp_reg;
    assign lamp_strike  = strike_reg;
    assign cmd_done     = done_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    pan_word_a: assert property (frame_done && !speed_mode && axis_wide[0]
        && fn_slot[0] == `FCD_SLOT_PAN |=> axis_pos[0] == $past({slot_reg[0], slot_reg[1]}))
        else $error("pan word not high then low byte");
    tilt_word_a: assert property (frame_done && !speed_mode && axis_wide[1]
        && fn_slot[1] == `FCD_SLOT_TILT |=> axis_pos[1] == $past({slot_reg[2], slot_reg[3]}))
        else $error("tilt word wrong");
    color_full_a: assert property (frame_done && !axis_wide[2] && slot_reg[4] == 8'hFF
        && fn_slot[2] == `FCD_SLOT_COLOR |=> axis_pos[2] == 16'hFFFF)
        else $error("color roll full scale not last frame");
    shut_zero_a: assert property (frame_done && fn_slot[3] == `FCD_SLOT_SHUTTER
        && slot_reg[6] == 8'h00 && slot_reg[7] == 8'h00 |=> axis_pos[3] == 16'h0000)
        else $error("shutter zero not closed");
    focus_full_a: assert property (frame_done && !speed_mode && axis_wide[4]
        && fn_slot[4] == `FCD_SLOT_FOCUS && slot_reg[8] == 8'hFF && slot_reg[9] == 8'hFF
        |=> axis_pos[4] == 16'hFFFF) else $error("focus full scale not flood");
    noact_idle_a: assert property (st_reg == fcd_pkg::FCD_ST_IDLE
        && cmd_live == fcd_pkg::FCD_CMD_NONE |=> st_reg == fcd_pkg::FCD_ST_IDLE)
        else $error("no-action code started a hold");
    pan_capture_a: assert property (exec && cmd_live == fcd_pkg::FCD_CMD_PAN_MIN
        && held_reg == fcd_pkg::FCD_ACT_ON |=> limit_word[0] == $past(pos_reg[0]))
        else $error("pan minimum not captured");
    limit_reset_a: assert property (exec && cmd_live == fcd_pkg::FCD_CMD_TILT_MAX
        && held_reg == fcd_pkg::FCD_ACT_RESET |=> limit_word[3] == `FCD_LIM_MAX_RST)
        else $error("tilt maximum not restored");
    servo_off_a: assert property (exec && cmd_live == fcd_pkg::FCD_CMD_SERVO_OFF
        |=> !servo_enable && cmd_done)
        else $error("servos not disabled");
    strike_a: assert property (exec && cmd_live == fcd_pkg::FCD_CMD_LAMP_ON
        |=> lamp_strike && lamp_enable ##1 !lamp_strike)
        else $error("lamp strike not a single pulse");
    once_only_a: assert property (cmd_done
        |=> !cmd_done && st_reg != fcd_pkg::FCD_ST_HOLD)
        else $error("command ran twice in one activation");
    speed_take_a: assert property (frame_done && speed_mode
        && fn_slot[0] == `FCD_SLOT_PAN |=> axis_speed[0] == $past(slot_reg[1]))
        else $error("speed slot not taken");

    recal_all_c: cover property (exec && cmd_live == fcd_pkg::FCD_CMD_RECAL_ALL);
    reset_lim_c: cover property (exec && held_reg == fcd_pkg::FCD_ACT_RESET);
    abort_c:     cover property (st_reg == fcd_pkg::FCD_ST_HOLD ##1 st_reg == fcd_pkg::FCD_ST_IDLE);
    speed_c:     cover property (frame_done && speed_mode);

endmodule : fcd_decoder

// File: fcd_console.sv
// fcd_console.sv: console model that sends slot frames to the decoder
// assumes: ref_clk comes from the bench; the decoder samples on the rising edge
`timescale 1ns/1ps

module fcd_console (
    input  wire logic       ref_clk,
    output logic            slot_wr,
    output logic [3:0]      slot_idx,
    output logic [7:0]      slot_data,
    output logic            frame_done
);
    logic [7:0] slot_val [12];

    initial begin
        slot_wr    = 1'b0;
        slot_idx   = 4'h0;
        slot_data  = 8'h00;
        frame_done = 1'b0;
        for (int i = 0; i < 12; i++) begin
            slot_val[i] = 8'h00;
        end
    end

    task automatic load(input int i, input logic [7:0] v);
        slot_val[i] = v;
    endtask : load

    // =====================================================================
    // frame transfer
    // values change in one step per frame, never faded
    task automatic send_frame();
        for (int i = 0; i < 12; i++) begin
            @(negedge ref_clk);
            slot_wr   = 1'b1;
            slot_idx  = i[3:0];
            slot_data = slot_val[i];
        end
        // first slot index past the fixture, must be dropped
        @(negedge ref_clk);
        slot_idx  = 4'hC;
        slot_data = 8'h5A;
        @(negedge ref_clk);
        slot_wr    = 1'b0;
        slot_idx   = ~slot_idx;
        slot_data  = ~slot_data;
        frame_done = 1'b1;
        @(negedge ref_clk);
        frame_done = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : send_frame

    // =====================================================================
    // remote command: hold the level well past the hold time, then idle
    task automatic activate(input logic [7:0] code, input logic [7:0] level);
        slot_val[10] = code;
        slot_val[11] = level;
        send_frame();
        repeat (20) @(negedge ref_clk);
        send_frame();
        slot_val[11] = 8'h00;
        send_frame();
        repeat (4) @(negedge ref_clk);
    endtask : activate
endmodule : fcd_console

// File: fcd_decoder_bench.sv
// fcd_decoder_bench.sv: self-checking bench for the fixture command decoder
// assumes: fcd_console as slot source; hold time shortened by parameter
`timescale 1ns/1ps
`include "fcd_consts.svh"

module fcd_decoder_bench;
    localparam int unsigned HOLD = 8;
    logic                 ref_clk;
    logic                 rst;
    logic                 slot_wr;
    logic [3:0]           slot_idx;
    logic [7:0]           slot_data;
    logic                 frame_done;
    logic                 speed_mode;
    logic [4:0]           axis_wide;
    logic [6:0][3:0]      fn_slot;
    logic [4:0][15:0]     axis_pos;
    logic [4:0][7:0]      axis_speed;
    logic [5:0][15:0]     limit_word;
    logic [3:0]           recal_pulse;
    logic                 servo_enable;
    logic                 lamp_enable;
    logic                 lamp_strike;
    logic                 cmd_done;
    logic [15:0]          done_cnt;
    logic [15:0]          strike_cnt;
    logic [3:0]           recal_seen;
    int                   n_fail;
    int                   check_count;
    int                   cycles;
    logic [7:0]           t16 [10] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'hFF, 8'hFF,
                                       8'h00, 8'h00, 8'h9A, 8'hBC};
    logic [7:0]           pv [5] = '{8'h40, 8'h80, 8'hFF, 8'h00, 8'hC0};
    logic [7:0]           sv [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};

    fcd_decoder #(.HOLD_CYCLES(HOLD)) fcd_decoder_i (
        .ref_clk(ref_clk), .rst(rst), .slot_wr(slot_wr), .slot_idx(slot_idx),
        .slot_data(slot_data), .frame_done(frame_done), .speed_mode(speed_mode),
        .axis_wide(axis_wide), .fn_slot(fn_slot), .axis_pos(axis_pos),
        .axis_speed(axis_speed), .limit_word(limit_word), .recal_pulse(recal_pulse),
        .servo_enable(servo_enable), .lamp_enable(lamp_enable),
        .lamp_strike(lamp_strike), .cmd_done(cmd_done)
    );

    fcd_console fcd_console_i (
        .ref_clk(ref_clk), .slot_wr(slot_wr), .slot_idx(slot_idx),
        .slot_data(slot_data), .frame_done(frame_done)
    );

    initial ref_clk = 1'b0;
    always #2.5 ref_clk = ~ref_clk;

    // =====================================================================
    // pulse monitors and hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cmd_done === 1'b1) done_cnt++;
        if (lamp_strike === 1'b1) strike_cnt++;
        recal_seen = recal_seen | recal_pulse;
        if (cycles == 10000) begin
            n_fail++;
            final_report();
        end
    end

    // =====================================================================
    // helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_end(input string name);
        $display("test %s done, failures so far %0d", name, n_fail);
    endtask : test_end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    task automatic put16();
        for (int i = 0; i < 10; i++) fcd_console_i.load(i, t16[i]);
        fcd_console_i.send_frame();
    endtask : put16

    function automatic logic [15:0] obs(input int k);
        if (k < 6) return limit_word[k];
        case (k)
            6: return {12'h000, recal_seen};
            7: return {15'h0000, servo_enable};
            8: return {15'h0000, lamp_enable};
            9: return strike_cnt;
            default: return done_cnt;
        endcase
    endfunction : obs

    task automatic run(input logic [7:0] code, input logic [7:0] lvl, input int k,
                       input logic [15:0] exp, input logic [15:0] ndone);
        done_cnt   = 16'h0000;
        strike_cnt = 16'h0000;
        recal_seen = 4'h0;
        fcd_console_i.activate(code, lvl);
        check($sformatf("cmd %0d level %0d", code, lvl), obs(k), exp);
        check("cmd_done count", done_cnt, ndone);
    endtask : run

    // =====================================================================
    // main sequence
    initial begin
        n_fail = 0; check_count = 0; cycles = 0;
        done_cnt = 16'h0000; strike_cnt = 16'h0000; recal_seen = 4'h0;
        rst = 1'b1; speed_mode = 1'b0; axis_wide = 5'h1F;
        fn_slot = {`FCD_SLOT_ACT, `FCD_SLOT_CMD, `FCD_SLOT_FOCUS, `FCD_SLOT_SHUTTER,
                   `FCD_SLOT_COLOR, `FCD_SLOT_TILT, `FCD_SLOT_PAN};
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        for (int a = 0; a < 5; a++) check("axis_pos reset", axis_pos[a], `FCD_POS_RST);
        for (int l = 0; l < 6; l++) check("limit reset", limit_word[l], l[0] ? 16'hFFFF : 16'h0000);
        check("servo reset", servo_enable, 1'b1);
        check("lamp reset", lamp_enable, 1'b0);
        test_end("reset");
        put16();
        check("pan 16", axis_pos[0], 16'h1234);
        check("tilt 16", axis_pos[1], 16'h5678);
        check("color 16", axis_pos[2], 16'hFFFF);
        check("shutter 16", axis_pos[3], 16'h0000);
        check("focus 16", axis_pos[4], 16'h9ABC);
        check("speed idle", axis_speed[0], 8'h00);
        axis_wide = 5'h00;
        fcd_console_i.send_frame();
        for (int a = 0; a < 5; a++) check("axis 8", axis_pos[a], {2{t16[2*a]}});
        test_end("widths");
        axis_wide = 5'h1F;
        fcd_console_i.send_frame();
        run(8'd51, 8'd255, 0, 16'h1234, 1);
        run(8'd76, 8'd230, 1, 16'h1234, 1);
        run(8'd77, 8'd255, 2, 16'h5678, 1);
        run(8'd101, 8'd255, 3, 16'h5678, 1);
        run(8'd102, 8'd255, 4, 16'h9ABC, 1);
        run(8'd127, 8'd255, 5, 16'h9ABC, 1);
        run(8'd51, 8'd130, 0, 16'h0000, 1);
        run(8'd63, 8'd130, 1, 16'hFFFF, 1);
        run(8'd128, 8'd255, 6, 16'h0001, 1);
        run(8'd152, 8'd255, 6, 16'h0002, 1);
        run(8'd153, 8'd255, 6, 16'h0004, 1);
        run(8'd178, 8'd255, 6, 16'h0008, 1);
        run(8'd179, 8'd255, 6, 16'h000F, 1);
        run(8'd191, 8'd255, 7, 16'h0000, 1);
        run(8'd216, 8'd255, 7, 16'h0001, 1);
        run(8'd241, 8'd255, 9, 16'h0001, 1);
        run(8'd230, 8'd255, 8, 16'h0001, 1);
        run(8'd217, 8'd255, 8, 16'h0000, 1);
        run(8'd50, 8'd255, 10, 16'h0000, 0);
        run(8'd242, 8'd255, 10, 16'h0000, 0);
        run(8'd51, 8'd129, 10, 16'h0000, 0);
        test_end("commands");
        speed_mode = 1'b1;
        for (int a = 0; a < 5; a++) begin
            fcd_console_i.load(2 * a, pv[a]);
            fcd_console_i.load(2 * a + 1, sv[a]);
        end
        fcd_console_i.send_frame();
        for (int a = 0; a < 5; a++) check("speed pos", axis_pos[a], {2{pv[a]}});
        for (int a = 0; a < 5; a++) check("speed val", axis_speed[a], sv[a]);
        test_end("speed");
        speed_mode = 1'b0;
        fn_slot[0] = `FCD_SLOT_FOCUS;
        fn_slot[4] = `FCD_SLOT_PAN;
        put16();
        check("pan patched", axis_pos[0], 16'h9ABC);
        check("focus patched", axis_pos[4], 16'h1234);
        test_end("patch");
        final_report();
    end
endmodule : fcd_decoder_bench
